// ===== hdl/uds_doze_rx.sv
// receive path that keeps working in stop mode through the doze state
// Operation
// [R01] doze armed in stop: receive without cpu
// [R02] stop without doze: all communication halted
// [R03] software arms doze only on fast oscillator
// [R04] suppress set: no error flag, no interrupt; the code still raises the completion interrupt for an errored frame
// [R05] software clears flags, reads data, then arms
// [R06] valid start edge moves stop into doze
// [R07] too short start pulse: stay doze, no transfer
// [R08] frame complete in doze raises completion interrupt
//
// Added by the designer: strobed register access and the address map.
`timescale 1ns/10ps
`include "uds_map.svh"
module uds_doze_rx #(
  parameter int DATA_BITS = 8
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic srst_in,
  // register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  // chip power status
  input wire logic stop_mode_in,
  input wire logic fast_osc_selected_in,
  // serial line
  input wire logic serial_receive_pin_in,
  // events and wake
  output logic receive_complete_interrupt_out,
  output logic receive_error_interrupt_out,
  output logic doze_receive_mode_out,
  output logic irq_out
);
  // elaboration checks: the receiver holds at most a byte, and the
  // interrupt and control words below are built for these map widths
  generate
    if (DATA_BITS < 5 || DATA_BITS > 8) begin : g_bad_bits
      $error("uds_doze_rx: DATA_BITS must be 5 to 8");
    end
    if (`UDS_IRQ_W != 2) begin : g_bad_irq
      $error("uds_doze_rx: exactly two interrupt events expected");
    end
    if (`UDS_CTRL_W <= `UDS_CTRL_SUPPRESS) begin : g_bad_ctrl
      $error("uds_doze_rx: control word too narrow for its fields");
    end
    if (`UDS_BAUD_MIN < 16'h0002) begin : g_bad_min
      $error("uds_doze_rx: shortest bit period cannot be centred");
    end
    if (`UDS_BAUD_RST < `UDS_BAUD_MIN) begin : g_bad_rst
      $error("uds_doze_rx: reset bit period below the clamp");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [`UDS_CTRL_W-1:0] ctrl;
  logic [15:0] baud;
  logic parity_error_flag;
  logic framing_error_flag;
  logic overrun_error_flag;
  logic [DATA_BITS-1:0] receive_data_register;
  logic data_full;
  logic [`UDS_IRQ_W-1:0] irq_stat;
  logic [`UDS_IRQ_W-1:0] irq_mask;
  uds_pkg::uds_doze_e doze_state;
  uds_pkg::uds_doze_e next_doze_state;
  logic line_q;

  // receiver results
  logic rx_busy;
  logic rx_done;
  logic rx_glitch;
  logic [DATA_BITS-1:0] rx_data;
  logic rx_perr;
  logic rx_ferr;

  ////////////////////////////////////////////////////////////////////////
  // decode
  wire sel_ctrl = (reg_addr_in == `UDS_OFS_CTRL);
  wire sel_baud = (reg_addr_in == `UDS_OFS_BAUD);
  wire sel_err = (reg_addr_in == `UDS_OFS_ERR);
  wire sel_data = (reg_addr_in == `UDS_OFS_DATA);
  wire sel_istat = (reg_addr_in == `UDS_OFS_ISTAT);
  wire sel_imask = (reg_addr_in == `UDS_OFS_IMASK);
  wire wr_ctrl = reg_wr_in && sel_ctrl;
  wire wr_baud = reg_wr_in && sel_baud;
  wire wr_err = reg_wr_in && sel_err;
  wire wr_istat = reg_wr_in && sel_istat;
  wire wr_imask = reg_wr_in && sel_imask;
  wire rd_data = reg_rd_in && sel_data;

  // control fields
  wire rx_en = ctrl[`UDS_CTRL_RX_EN];
  wire par_en = ctrl[`UDS_CTRL_PAR_EN];
  wire par_odd = ctrl[`UDS_CTRL_PAR_ODD];
  wire doze_wake_enable = ctrl[`UDS_CTRL_WAKE_EN];
  wire error_interrupt_suppress = ctrl[`UDS_CTRL_SUPPRESS];

  ////////////////////////////////////////////////////////////////////////
  // doze state machine
  // armed only on the fast oscillator; another source would leave the
  // bit clock wrong, so the arm is simply refused there
  wire doze_armed = rx_en && doze_wake_enable && fast_osc_selected_in; // [R03]
  // line_q resets to the idle level, so reset makes no false edge
  wire start_edge = line_q && !serial_receive_pin_in;

  always_comb begin
    next_doze_state = doze_state;
    case (doze_state)
      uds_pkg::UDS_RUN: begin
        if (stop_mode_in) next_doze_state = uds_pkg::UDS_HALT;
      end
      uds_pkg::UDS_HALT: begin
        if (!stop_mode_in) begin
          next_doze_state = uds_pkg::UDS_RUN;
        end else if (doze_armed && start_edge) begin
          next_doze_state = uds_pkg::UDS_DOZE; // [R06]
        end
      end
      uds_pkg::UDS_DOZE: begin
        // a rejected start pulse keeps us here until the next frame
        if (!stop_mode_in) next_doze_state = uds_pkg::UDS_RUN; // [R07]
        else if (!doze_armed) next_doze_state = uds_pkg::UDS_HALT;
      end
      default: next_doze_state = uds_pkg::UDS_RUN;
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      doze_state <= uds_pkg::UDS_RUN;
      line_q <= 1'b1;
    end else begin
      doze_state <= next_doze_state;
      line_q <= serial_receive_pin_in;
    end
  end

  // receiver runs in normal mode and in doze, never in plain stop
  // a frame in flight when a plain stop begins is dropped on purpose
  wire in_doze = (doze_state == uds_pkg::UDS_DOZE);
  wire rx_run = rx_en && ((doze_state == uds_pkg::UDS_RUN) || in_doze); // [R01] [R02]

  ////////////////////////////////////////////////////////////////////////
  // frame receiver
  uds_rx_core #(
    .DATA_BITS(DATA_BITS)
  ) u_rx (
    .clock_in(clock_in),
    .srst_in(srst_in),
    .enable_in(rx_run),
    .divisor_in(baud),
    .parity_en_in(par_en),
    .parity_odd_in(par_odd),
    .serial_receive_pin_in(serial_receive_pin_in),
    .busy_out(rx_busy),
    .done_out(rx_done),
    .glitch_out(rx_glitch),
    .data_out(rx_data),
    .parity_err_out(rx_perr),
    .framing_err_out(rx_ferr)
  );

  ////////////////////////////////////////////////////////////////////////
  // error and completion events
  // overrun: a byte lands while the last one is unread and not being read
  wire ovr_evt = rx_done && data_full && !rd_data;
  wire ev_perr = rx_done && rx_perr && !error_interrupt_suppress; // [R04]
  wire ev_ferr = rx_done && rx_ferr && !error_interrupt_suppress; // [R04]
  wire ev_ovr = ovr_evt && !error_interrupt_suppress; // [R04]
  wire ev_err = ev_perr || ev_ferr || ev_ovr;
  wire ev_done = rx_done; // [R08]

  // write-one-to-clear; a set in the same cycle wins
  wire [2:0] err_set = {ev_ovr, ev_ferr, ev_perr};
  wire [2:0] err_hit = {reg_wdata_in[`UDS_ERR_OVERRUN], reg_wdata_in[`UDS_ERR_FRAMING],
    reg_wdata_in[`UDS_ERR_PARITY]};
  wire [2:0] err_clr = {3{wr_err}} & err_hit;
  logic [2:0] err_flag;

  genvar ge;
  generate
    for (ge = 0; ge < 3; ge++) begin : g_err
      always_ff @(posedge clock_in) begin
        if (srst_in) begin
          err_flag[ge] <= 1'b0;
        end else if (err_set[ge]) begin
          err_flag[ge] <= 1'b1;
        end else if (err_clr[ge]) begin
          err_flag[ge] <= 1'b0;
        end
      end
    end
  endgenerate

  // named views of the sticky error bits
  assign parity_error_flag = err_flag[0];
  assign framing_error_flag = err_flag[1];
  assign overrun_error_flag = err_flag[2];

  // receive buffer; on overrun the new frame overwrites the old
  always_ff @(posedge clock_in) begin
    if (srst_in) receive_data_register <= '0;
    else if (rx_done) receive_data_register <= rx_data;
  end

  // full flag; a frame landing beside a read keeps it full, so no byte is lost silently
  always_ff @(posedge clock_in) begin
    if (srst_in) data_full <= 1'b0;
    else if (rx_done) data_full <= 1'b1;
    else if (rd_data) data_full <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // control registers
  always_ff @(posedge clock_in) begin
    if (srst_in) ctrl <= `UDS_CTRL_RST;
    else if (wr_ctrl) ctrl <= reg_wdata_in[`UDS_CTRL_W-1:0];
  end

  // a too small divisor cannot centre the samples; clamp it
  wire [15:0] baud_wr_value = (reg_wdata_in[15:0] < `UDS_BAUD_MIN) ? `UDS_BAUD_MIN :
    reg_wdata_in[15:0];
  always_ff @(posedge clock_in) begin
    if (srst_in) baud <= `UDS_BAUD_RST;
    else if (wr_baud) baud <= baud_wr_value;
  end

  // interrupt mask
  always_ff @(posedge clock_in) begin
    if (srst_in) irq_mask <= `UDS_IMASK_RST;
    else if (wr_imask) irq_mask <= reg_wdata_in[`UDS_IRQ_W-1:0];
  end

  // sticky interrupt status, one bit per event
  wire [`UDS_IRQ_W-1:0] irq_set = {ev_err, ev_done};

  genvar gi;
  generate
    for (gi = 0; gi < `UDS_IRQ_W; gi++) begin : g_irq
      always_ff @(posedge clock_in) begin
        if (srst_in) begin
          irq_stat[gi] <= 1'b0;
        end else if (irq_set[gi]) begin
          irq_stat[gi] <= 1'b1;
        end else if (wr_istat && reg_wdata_in[gi]) begin
          irq_stat[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // read path, answered one cycle after the strobe
  wire [31:0] err_word;
  assign err_word = {
    24'h000000,
    doze_state, // 7:6 run, halt or doze
    rx_busy, // 5 frame in progress
    data_full, // 4 unread byte waiting
    1'b0, // 3 spare
    overrun_error_flag,
    framing_error_flag,
    parity_error_flag
  };

  wire [31:0] rd_mux =
    sel_ctrl ? {{(32-`UDS_CTRL_W){1'b0}}, ctrl} :
    sel_baud ? {16'h0000, baud} :
    sel_err ? err_word :
    sel_data ? {{(32-DATA_BITS){1'b0}}, receive_data_register} :
    sel_istat ? {{(32-`UDS_IRQ_W){1'b0}}, irq_stat} :
    sel_imask ? {{(32-`UDS_IRQ_W){1'b0}}, irq_mask} :
    32'h00000000; // unmapped reads zero

  always_ff @(posedge clock_in) begin
    if (srst_in) reg_rdata_out <= 32'h00000000;
    else if (reg_rd_in) reg_rdata_out <= rd_mux;
    else reg_rdata_out <= 32'h00000000;
  end

  ////////////////////////////////////////////////////////////////////////
  // event pulses and interrupt line
  always_ff @(posedge clock_in) begin
    if (srst_in) receive_complete_interrupt_out <= 1'b0;
    else receive_complete_interrupt_out <= ev_done; // [R08]
  end

  // error pulse stays silent while suppression is set
  always_ff @(posedge clock_in) begin
    if (srst_in) receive_error_interrupt_out <= 1'b0;
    else receive_error_interrupt_out <= ev_err; // [R04]
  end

  // rx_glitch needs no action: the machine simply stays in doze
  // until a real frame, whose errors land in the flags as for any frame
  wire unused_glitch = rx_glitch;

  assign doze_receive_mode_out = in_doze;
  assign irq_out = |(irq_stat & irq_mask);
endmodule : uds_doze_rx

// ===== hdl/uds_map.svh
// register offsets, field positions, reset values and timing counts
`ifndef UDS_MAP_SVH
`define UDS_MAP_SVH
// register byte offsets
`define UDS_OFS_CTRL 8'h00
`define UDS_OFS_BAUD 8'h04
`define UDS_OFS_ERR 8'h08
`define UDS_OFS_DATA 8'h0c
`define UDS_OFS_ISTAT 8'h10
`define UDS_OFS_IMASK 8'h14
// control field positions
`define UDS_CTRL_RX_EN 0
`define UDS_CTRL_PAR_EN 1
`define UDS_CTRL_PAR_ODD 2
`define UDS_CTRL_WAKE_EN 3
`define UDS_CTRL_SUPPRESS 4
`define UDS_CTRL_W 5
// error / status field positions
`define UDS_ERR_PARITY 0
`define UDS_ERR_FRAMING 1
`define UDS_ERR_OVERRUN 2
`define UDS_ERR_FULL 4
`define UDS_ERR_BUSY 5
`define UDS_ERR_STATE_LO 6
// interrupt status field positions
`define UDS_IRQ_DONE 0
`define UDS_IRQ_ERROR 1
`define UDS_IRQ_W 2
// reset values
`define UDS_CTRL_RST 5'h00
`define UDS_BAUD_RST 16'h043d
`define UDS_IMASK_RST 2'h0
// timing: shortest legal bit period in clock cycles
`define UDS_BAUD_MIN 16'h0004
`endif

// ===== hdl/uds_pkg.sv
// types shared by the doze receive block
package uds_pkg;
  // power / doze state of the receive path
  typedef enum logic [1:0] {
    UDS_RUN = 2'b00,
    UDS_HALT = 2'b01,
    UDS_DOZE = 2'b10
  } uds_doze_e;
  // frame receiver state
  typedef enum logic [2:0] {
    UDS_RX_IDLE = 3'b000,
    UDS_RX_START = 3'b001,
    UDS_RX_DATA = 3'b010,
    UDS_RX_PAR = 3'b011,
    UDS_RX_STOP = 3'b100
  } uds_rx_e;
endpackage : uds_pkg

// ===== hdl/uds_rx_core.sv
// serial frame receiver: start check, data, optional parity, stop
`timescale 1ns/10ps
module uds_rx_core #(
  parameter int DATA_BITS = 8
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic srst_in,
  // configuration
  input wire logic enable_in,
  input wire logic [15:0] divisor_in,
  input wire logic parity_en_in,
  input wire logic parity_odd_in,
  // line
  input wire logic serial_receive_pin_in,
  // results
  output logic busy_out,
  output logic done_out,
  output logic glitch_out,
  output logic [DATA_BITS-1:0] data_out,
  output logic parity_err_out,
  output logic framing_err_out
);
  generate
    if (DATA_BITS < 5 || DATA_BITS > 8) begin : g_bad_bits
      $error("uds_rx_core: DATA_BITS must be 5 to 8");
    end
  endgenerate

  uds_pkg::uds_rx_e state;
  uds_pkg::uds_rx_e next_state;
  logic [15:0] cnt;
  logic [3:0] bit_idx;
  logic [DATA_BITS-1:0] shift;
  logic par_acc;
  wire tick = (cnt == 16'h0000);
  wire line = serial_receive_pin_in;
  wire last_bit = (bit_idx == 4'(DATA_BITS - 1));
  wire [15:0] full_bit = divisor_in - 16'h0001;

  // next state of the frame walk
  always_comb begin
    next_state = state;
    case (state)
      uds_pkg::UDS_RX_IDLE: if (!line) next_state = uds_pkg::UDS_RX_START;
      uds_pkg::UDS_RX_START: if (tick) begin
        next_state = line ? uds_pkg::UDS_RX_IDLE : uds_pkg::UDS_RX_DATA; // [R07]
      end
      uds_pkg::UDS_RX_DATA: if (tick && last_bit) begin
        next_state = parity_en_in ? uds_pkg::UDS_RX_PAR : uds_pkg::UDS_RX_STOP;
      end
      uds_pkg::UDS_RX_PAR: if (tick) next_state = uds_pkg::UDS_RX_STOP;
      uds_pkg::UDS_RX_STOP: if (tick) next_state = uds_pkg::UDS_RX_IDLE;
      default: next_state = uds_pkg::UDS_RX_IDLE;
    endcase
    if (!enable_in) next_state = uds_pkg::UDS_RX_IDLE;
  end

  // state and bit timer; sampling at mid-bit
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      state <= uds_pkg::UDS_RX_IDLE;
      cnt <= 16'h0000;
      bit_idx <= 4'h0;
    end else begin
      state <= next_state;
      if (state == uds_pkg::UDS_RX_IDLE) begin
        cnt <= {1'b0, divisor_in[15:1]}; // half a bit to the start centre
        bit_idx <= 4'h0;
      end else if (tick) begin
        cnt <= full_bit;
        if (state == uds_pkg::UDS_RX_DATA) bit_idx <= bit_idx + 4'h1;
      end else begin
        cnt <= cnt - 16'h0001;
      end
    end
  end

  // data shift, parity and results
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      shift <= '0;
      par_acc <= 1'b0;
      done_out <= 1'b0;
      glitch_out <= 1'b0;
      data_out <= '0;
      parity_err_out <= 1'b0;
      framing_err_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      glitch_out <= enable_in && (state == uds_pkg::UDS_RX_START) && tick && line; // [R07]
      if (state == uds_pkg::UDS_RX_START) par_acc <= parity_odd_in;
      if (tick && state == uds_pkg::UDS_RX_DATA) begin
        shift <= {line, shift[DATA_BITS-1:1]}; // lsb first
        par_acc <= par_acc ^ line;
      end
      if (tick && state == uds_pkg::UDS_RX_PAR) par_acc <= par_acc ^ line;
      if (enable_in && tick && state == uds_pkg::UDS_RX_STOP) begin
        done_out <= 1'b1;
        data_out <= shift;
        parity_err_out <= parity_en_in && par_acc;
        framing_err_out <= !line;
      end
    end
  end

  assign busy_out = (state != uds_pkg::UDS_RX_IDLE);
endmodule : uds_rx_core

// ===== tb/uds_doze_rx_properties.sv
// checker on the ports of the doze receive block
`timescale 1ns/10ps
module uds_doze_rx_checker (
  // clock and reset
  input wire logic clock_in,
  input wire logic srst_in,
  // register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  // power and line
  input wire logic stop_mode_in,
  input wire logic fast_osc_selected_in,
  input wire logic serial_receive_pin_in,
  // events
  input wire logic receive_complete_interrupt_out,
  input wire logic receive_error_interrupt_out,
  input wire logic doze_receive_mode_out,
  input wire logic irq_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (srst_in);
  ////////////////////////////////////////////////////////////////
  // read data only in the cycle after a strobe
  property p_rdata_idle;
    !$past(reg_rd_in) |-> reg_rdata_out == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside its cycle");
  property p_doze_entry;
    $rose(doze_receive_mode_out) |-> $past(stop_mode_in) && !$past(serial_receive_pin_in);
  endproperty
  a_doze_entry: assert property (p_doze_entry) else $error("doze without edge");
  property p_doze_in_stop;
    doze_receive_mode_out |-> $past(stop_mode_in) && $past(fast_osc_selected_in);
  endproperty
  a_doze_in_stop: assert property (p_doze_in_stop) else $error("doze outside stop");
  // halted path must stay silent
  property p_halt_quiet;
    stop_mode_in && $past(stop_mode_in) && !doze_receive_mode_out && !$past(doze_receive_mode_out)
      |-> !receive_complete_interrupt_out && !receive_error_interrupt_out;
  endproperty
  a_halt_quiet: assert property (p_halt_quiet) else $error("event while halted");
  property p_done_pulse;
    receive_complete_interrupt_out |=> !receive_complete_interrupt_out [*8];
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("complete pulse too long");
  property p_err_pulse;
    receive_error_interrupt_out |=> !receive_error_interrupt_out [*8];
  endproperty
  a_err_pulse: assert property (p_err_pulse) else $error("error pulse too long");
  // a short pulse must not drop the doze state
  property p_doze_hold;
    $past(doze_receive_mode_out) && $past(stop_mode_in) && $past(fast_osc_selected_in)
      && !$past(reg_wr_in) && !$past(reg_wr_in, 2) |-> doze_receive_mode_out;
  endproperty
  a_doze_hold: assert property (p_doze_hold) else $error("doze dropped");
  c_doze: cover property ($rose(doze_receive_mode_out));
  c_done_doze: cover property (doze_receive_mode_out && receive_complete_interrupt_out);
  c_err: cover property (receive_error_interrupt_out);
endmodule : uds_doze_rx_checker
bind uds_doze_rx uds_doze_rx_checker uds_doze_rx_checker_inst (.clock_in, .srst_in,
  .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .stop_mode_in,
  .fast_osc_selected_in, .serial_receive_pin_in, .receive_complete_interrupt_out,
  .receive_error_interrupt_out, .doze_receive_mode_out, .irq_out);

// ===== tb/uds_doze_rx_tb_top.sv
// testbench for the doze receive block
`timescale 1ns/10ps
`include "uds_map.svh"
module uds_doze_rx_tb_top;
  logic clock_in, srst_in, wr, rd, stop_mode, fast_osc, line, done, err, doze, irq;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, d;
  int bad_count = 0;
  int tests_run = 0;
  int cycles = 0;
  int n_done = 0;
  int n_err = 0;
  int nd, ne, k;
  localparam logic [31:0] RXEN = 32'h1 << `UDS_CTRL_RX_EN;
  localparam logic [31:0] PAR = 32'h3 << `UDS_CTRL_PAR_EN;
  localparam logic [31:0] PEV = 32'h1 << `UDS_CTRL_PAR_EN;
  localparam logic [31:0] WAKE = 32'h1 << `UDS_CTRL_WAKE_EN;
  localparam logic [31:0] SUP = 32'h1 << `UDS_CTRL_SUPPRESS;
  uds_doze_rx uds_doze_rx_inst (.clock_in(clock_in), .srst_in(srst_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .stop_mode_in(stop_mode), .fast_osc_selected_in(fast_osc), .serial_receive_pin_in(line),
    .receive_complete_interrupt_out(done), .receive_error_interrupt_out(err),
    .doze_receive_mode_out(doze), .irq_out(irq));
  uds_serial_source uds_serial_source_inst (.clock_in(clock_in), .line_out(line));
  ////////////////////////////////////////////////////////////////
  initial begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end
  // event counters and hang guard
  always @(posedge clock_in) begin
    cycles++;
    if (done === 1'b1) n_done++;
    if (err === 1'b1) n_err++;
    if (cycles == 8000) begin
      bad_count++;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
    end
  endtask : chk
  task automatic wreg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock_in);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clock_in);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clock_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock_in);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask : rreg
  // send one frame, parity sense given by odd; counts events it caused
  task automatic frame(input logic [7:0] v, input logic pe, input logic odd,
                       input logic bp, input logic bs);
    int d0, e0;
    d0 = n_done;
    e0 = n_err;
    uds_serial_source_inst.send(v, pe, odd, bp, bs);
    repeat (8) @(posedge clock_in);
    #1;
    nd = n_done - d0;
    ne = n_err - e0;
  endtask : frame
  task automatic settle;
    repeat (2) @(posedge clock_in);
    #1;
  endtask : settle
  ////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rreg(`UDS_OFS_CTRL, d);
    chk(d, `UDS_CTRL_RST, "ctrl reset");
    rreg(`UDS_OFS_BAUD, d);
    chk(d, `UDS_BAUD_RST, "baud reset");
    rreg(`UDS_OFS_IMASK, d);
    chk(d, `UDS_IMASK_RST, "mask reset");
    rreg(8'h1c, d);
    chk(d, 32'h0, "unmapped read");
    wreg(`UDS_OFS_BAUD, 32'h2);
    rreg(`UDS_OFS_BAUD, d);
    chk(d, `UDS_BAUD_MIN, "baud clamp");
    wreg(`UDS_OFS_BAUD, 32'h10);
    $display("test regs finished");
  endtask : t_regs
  task automatic t_run;
    wreg(`UDS_OFS_CTRL, RXEN);
    frame(8'ha5, 1'b0, 1'b0, 1'b0, 1'b0);
    chk(nd, 1, "complete count");
    chk(irq, 1'b0, "masked irq");
    rreg(`UDS_OFS_ISTAT, d);
    chk(d, 32'h1, "status done");
    wreg(`UDS_OFS_IMASK, 32'h3);
    settle();
    chk(irq, 1'b1, "irq raised");
    rreg(`UDS_OFS_DATA, d);
    chk(d, 32'ha5, "run data");
    wreg(`UDS_OFS_ISTAT, 32'h1);
    settle();
    chk(irq, 1'b0, "irq cleared");
    wreg(`UDS_OFS_CTRL, RXEN | PEV);
    frame(8'h96, 1'b1, 1'b0, 1'b0, 1'b0);
    chk(nd, 1, "even parity complete");
    chk(ne, 0, "even parity clean");
    $display("test run finished");
  endtask : t_run
  // parity, framing and overrun, each with and without suppression
  task automatic t_err;
    for (int s = 0; s < 2; s++) begin
      for (int e = 0; e < 3; e++) begin
        wreg(`UDS_OFS_ERR, 32'h7);
        rreg(`UDS_OFS_DATA, d);
        wreg(`UDS_OFS_CTRL, RXEN | PAR | (s ? SUP : 32'h0));
        if (e == 2) frame(8'h5a, 1'b1, 1'b1, 1'b0, 1'b0);
        frame(8'h69, 1'b1, 1'b1, e == 0, e == 1);
        chk(nd, 1, "complete with error");
        chk(ne, s ? 0 : 1, "error pulse");
        rreg(`UDS_OFS_ERR, d);
        chk(d & 32'h7, s ? 32'h0 : 32'h1 << e, "error flags");
        rreg(`UDS_OFS_ISTAT, d);
        chk(d & 32'h2, s ? 32'h0 : 32'h2, "error status");
        wreg(`UDS_OFS_ISTAT, 32'h3);
      end
    end
    wreg(`UDS_OFS_ISTAT, 32'h3);
    $display("test errors finished");
  endtask : t_err
  task automatic t_halt;
    wreg(`UDS_OFS_CTRL, RXEN);
    @(posedge clock_in);
    stop_mode <= 1'b1;
    settle();
    rreg(`UDS_OFS_ERR, d);
    chk(d & 32'hc0, 32'h40, "halt state");
    frame(8'h33, 1'b0, 1'b0, 1'b0, 1'b0);
    chk(nd, 0, "no receive halted");
    $display("test halt finished");
  endtask : t_halt
  task automatic t_doze;
    wreg(`UDS_OFS_ERR, 32'h7);
    rreg(`UDS_OFS_DATA, d);
    wreg(`UDS_OFS_CTRL, RXEN | WAKE);
    k = n_done;
    uds_serial_source_inst.blip(2);
    repeat (50) @(posedge clock_in);
    #1;
    chk(doze, 1'b1, "edge enters doze");
    chk(n_done - k, 0, "short pulse no frame");
    frame(8'h3c, 1'b0, 1'b0, 1'b0, 1'b0);
    chk(nd, 1, "doze complete");
    rreg(`UDS_OFS_DATA, d);
    chk(d, 32'h3c, "doze data");
    chk(doze, 1'b1, "doze kept");
    @(posedge clock_in);
    stop_mode <= 1'b0;
    settle();
    chk(doze, 1'b0, "doze left");
    $display("test doze finished");
  endtask : t_doze
  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report
  initial begin
    srst_in = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    stop_mode = 1'b0;
    fast_osc = 1'b1;
    repeat (8) @(posedge clock_in);
    srst_in <= 1'b0;
    t_regs();
    t_run();
    t_err();
    t_halt();
    t_doze();
    final_report();
  end
endmodule : uds_doze_rx_tb_top

// ===== tb/uds_serial_source.sv
// remote serial transmitter driving the receive line
`timescale 1ns/10ps
module uds_serial_source (
  // clock
  input wire logic clock_in,
  // line
  output logic line_out
);
  int bit_cycles = 16;
  initial line_out = 1'b1;
  ////////////////////////////////////////////////////////////////
  // one cell held n cycles
  task automatic put(input logic b, input int n);
    line_out <= b;
    repeat (n) @(posedge clock_in);
  endtask : put
  // lsb first; a bad stop is cut short, and the receiver rejects its low tail as a too short start
  task automatic send(input logic [7:0] v, input logic pe, input logic odd,
                      input logic bp, input logic bs);
    @(posedge clock_in);
    put(1'b0, bit_cycles);
    for (int i = 0; i < 8; i++) put(v[i], bit_cycles);
    if (pe) put(^v ^ odd ^ bp, bit_cycles);
    put(~bs, bs ? bit_cycles * 3 / 4 : bit_cycles);
    line_out <= 1'b1;
  endtask : send
  // low pulse shorter than half a bit
  task automatic blip(input int n);
    @(posedge clock_in);
    put(1'b0, n);
    line_out <= 1'b1;
  endtask : blip
endmodule : uds_serial_source
